//--- shared/acb_cfg.svh
// Offsets, field positions, reset values and sizes of the capture buffer control
`ifndef ACB_CFG_SVH
`define ACB_CFG_SVH

// ==========================================================
// Register map (byte addresses)
`define ACB_ADDR_W          8
`define ACB_ADDR_CTRL       8'h00
`define ACB_ADDR_STATUS     8'h04

// ==========================================================
// Control register fields
`define ACB_CTRL_W          7
`define ACB_CTRL_DEPTH_LO   0
`define ACB_CTRL_DEPTH_HI   1
`define ACB_CTRL_AUTO_STOP  2
`define ACB_CTRL_EDGE_SEL   3
`define ACB_CTRL_TEST       4
`define ACB_CTRL_FULL_SD    5
`define ACB_CTRL_CONV_SD    6
`define ACB_CTRL_RESET      7'h08

// ==========================================================
// Status register fields
`define ACB_STAT_EMPTY      0
`define ACB_STAT_FULL       1
`define ACB_STAT_WRITING    2
`define ACB_STAT_READ_OK    3
`define ACB_STAT_COUNT_LSB  16

// ==========================================================
// Buffer geometry
`define ACB_PTR_W           10
`define ACB_CNT_W           11
`define ACB_MEM_DEPTH       1024
`define ACB_DEPTH_256       11'h100
`define ACB_DEPTH_512       11'h200
`define ACB_DEPTH_1024      11'h400
`define ACB_TEST_LEN        3'h5

`endif

//--- shared/acb_pkg.sv
// Types shared by the capture buffer control design
`default_nettype none
package acb_pkg;

    typedef enum logic [1:0] {
        ACB_DEPTH_BYPASS = 2'h0,
        ACB_DEPTH_SMALL  = 2'h1,
        ACB_DEPTH_MID    = 2'h2,
        ACB_DEPTH_LARGE  = 2'h3
    } acb_depth_code_type;

    typedef enum logic [3:0] {
        ACB_MODE_OFF    = 4'h1,
        ACB_MODE_BYPASS = 4'h2,
        ACB_MODE_BUFFER = 4'h4,
        ACB_MODE_TEST   = 4'h8
    } acb_mode_type;

    typedef enum logic [1:0] {
        ACB_RESP_OKAY   = 2'h0,
        ACB_RESP_SLVERR = 2'h2
    } acb_resp_type;

endpackage : acb_pkg
`default_nettype wire

//--- src/acb_mem.sv
// Byte store of the capture buffer, one write port, registered read port
`timescale 1ns/100ps
`default_nettype none
`include "acb_cfg.svh"

module acb_mem (
    input  wire logic                   aclk,
    input  wire logic                   we,
    input  wire logic [`ACB_PTR_W-1:0]  waddr,
    input  wire logic [7:0]             wdata,
    input  wire logic [`ACB_PTR_W-1:0]  raddr,
    output var  logic [7:0]             rdata_reg
);

    logic [7:0] store [0:`ACB_MEM_DEPTH-1];

    always_ff @(posedge aclk) begin
        if (we) begin
            store[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        rdata_reg <= store[raddr];
    end

endmodule : acb_mem
`default_nettype wire

//--- src/acb_ctrl.sv
// Capture buffer control: gates, pointers, flags, output port and register slave
`timescale 1ns/100ps
`default_nettype none
`include "acb_cfg.svh"

module acb_ctrl (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`ACB_ADDR_W-1:0] awaddr,
    input  wire logic                   awvalid,
    output var  logic                   awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output var  logic                   wready,
    output var  logic [1:0]             bresp,
    output var  logic                   bvalid,
    input  wire logic                   bready,
    input  wire logic [`ACB_ADDR_W-1:0] araddr,
    input  wire logic                   arvalid,
    output var  logic                   arready,
    output var  logic [31:0]            rdata,
    output var  logic [1:0]             rresp,
    output var  logic                   rvalid,
    input  wire logic                   rready,
    input  wire logic [7:0]             sample_data,
    input  wire logic                   write_gate,
    input  wire logic                   read_gate,
    input  wire logic                   readout_clock,
    output var  logic [7:0]             data_out,
    output var  logic                   output_strobe,
    output var  logic                   buffer_empty_flag,
    output var  logic                   buffer_full_flag
);

    // ==========================================================
    // Pin synchronisers
    logic                    wg_s1_reg, wg_s2_reg;
    logic                    rg_s1_reg, rg_s2_reg;
    logic                    rck_s1_reg, rck_s2_reg, rck_s3_reg;
    logic                    rck_rise, rck_fall;

    always_ff @(posedge aclk) begin
        wg_s1_reg  <= write_gate;
        wg_s2_reg  <= wg_s1_reg;
        rg_s1_reg  <= read_gate;
        rg_s2_reg  <= rg_s1_reg;
        rck_s1_reg <= readout_clock;
        rck_s2_reg <= rck_s1_reg;
        rck_s3_reg <= rck_s2_reg;
    end

    assign rck_rise = rck_s2_reg & ~rck_s3_reg;
    assign rck_fall = ~rck_s2_reg & rck_s3_reg;

    // ==========================================================
    // Control register fields
    logic [`ACB_CTRL_W-1:0]       ctrl_reg;
    acb_pkg::acb_depth_code_type  depth_code;
    acb_pkg::acb_mode_type        mode;
    logic                         auto_stop, edge_sel, test_mode, full_sd, conv_sd;
    logic [`ACB_CNT_W-1:0]        depth;
    logic [`ACB_PTR_W-1:0]        mask;

    assign depth_code = acb_pkg::acb_depth_code_type'({ctrl_reg[`ACB_CTRL_DEPTH_HI],
                                                       ctrl_reg[`ACB_CTRL_DEPTH_LO]});
    assign auto_stop  = ctrl_reg[`ACB_CTRL_AUTO_STOP];
    assign edge_sel   = ctrl_reg[`ACB_CTRL_EDGE_SEL];
    assign test_mode  = ctrl_reg[`ACB_CTRL_TEST];
    assign full_sd    = ctrl_reg[`ACB_CTRL_FULL_SD];
    assign conv_sd    = ctrl_reg[`ACB_CTRL_CONV_SD];

    always_comb begin
        unique case (depth_code)
            acb_pkg::ACB_DEPTH_BYPASS: depth = `ACB_DEPTH_1024;
            acb_pkg::ACB_DEPTH_SMALL:  depth = `ACB_DEPTH_256;
            acb_pkg::ACB_DEPTH_MID:    depth = `ACB_DEPTH_512;
            acb_pkg::ACB_DEPTH_LARGE:  depth = `ACB_DEPTH_1024;
        endcase
        mask = depth[`ACB_PTR_W-1:0] - 10'h001;
    end

    // test mode outranks the depth setting
    always_comb begin
        if (full_sd) begin
            mode = acb_pkg::ACB_MODE_OFF;
        end else if (test_mode) begin
            mode = acb_pkg::ACB_MODE_TEST;
        end else if (depth_code == acb_pkg::ACB_DEPTH_BYPASS) begin
            mode = acb_pkg::ACB_MODE_BYPASS;
        end else begin
            mode = acb_pkg::ACB_MODE_BUFFER;
        end
    end

    // ==========================================================
    // Capture and readout pointers
    logic [`ACB_PTR_W-1:0]  wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [`ACB_CNT_W-1:0]  count_reg, count_next;
    logic                   read_ok_reg, read_ok_next;
    logic                   wr_active, wr_active_d_reg, wr_start;
    logic                   at_depth, mem_we, rd_step, read_phase;
    logic [`ACB_PTR_W-1:0]  mem_waddr;
    logic [7:0]             mem_rdata;

    // write gate ignored in converter shutdown
    assign wr_active = wg_s2_reg & (mode == acb_pkg::ACB_MODE_BUFFER) & ~conv_sd;
    assign wr_start  = wr_active & ~wr_active_d_reg;
    assign at_depth  = count_reg >= depth;
    assign mem_we    = wr_start | (wr_active & ~(at_depth & auto_stop));
    assign mem_waddr = wr_start ? '0 : wptr_reg;

    assign read_phase = rg_s2_reg & ~wr_active & (mode == acb_pkg::ACB_MODE_BUFFER)
                        & read_ok_reg & (count_reg != '0);
    assign rd_step    = read_phase & rck_rise;

    always_comb begin
        wptr_next    = wptr_reg;
        rptr_next    = rptr_reg;
        count_next   = count_reg;
        read_ok_next = read_ok_reg;
        if (wr_start) begin
            wptr_next    = 10'h001;
            rptr_next    = '0;
            count_next   = 11'h001;
            read_ok_next = 1'b0;
        end else if (mem_we) begin
            wptr_next = (wptr_reg + 10'h001) & mask;
            if (at_depth) begin
                rptr_next = (rptr_reg + 10'h001) & mask;
            end else begin
                count_next = count_reg + 11'h001;
            end
        end else if (rd_step) begin
            rptr_next  = (rptr_reg + 10'h001) & mask;
            count_next = count_reg - 11'h001;
        end
        // readable only after a full fill
        if (count_next >= depth) begin
            read_ok_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr_reg        <= '0;
            rptr_reg        <= '0;
            count_reg       <= '0;
            read_ok_reg     <= 1'b0;
            wr_active_d_reg <= 1'b0;
        end else begin
            wptr_reg        <= wptr_next;
            rptr_reg        <= rptr_next;
            count_reg       <= count_next;
            read_ok_reg     <= read_ok_next;
            wr_active_d_reg <= wr_active;
        end
    end

    acb_mem u_mem (
        .aclk      (aclk),
        .we        (mem_we),
        .waddr     (mem_waddr),
        .wdata     (sample_data),
        .raddr     (rptr_reg),
        .rdata_reg (mem_rdata)
    );

    // ==========================================================
    // Flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buffer_empty_flag <= 1'b1;
            buffer_full_flag  <= 1'b0;
        end else if (mode != acb_pkg::ACB_MODE_BUFFER) begin
            // flags held low outside buffered mode
            buffer_empty_flag <= 1'b0;
            buffer_full_flag  <= 1'b0;
        end else begin
            buffer_empty_flag <= count_next == '0;
            buffer_full_flag  <= count_next >= depth;
        end
    end

    // ==========================================================
    // Output port
    logic [2:0] test_idx_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_idx_reg <= '0;
        end else if (mode != acb_pkg::ACB_MODE_TEST) begin
            test_idx_reg <= '0;
        end else if (rck_rise) begin
            test_idx_reg <= (test_idx_reg == `ACB_TEST_LEN - 3'h1) ? 3'h0
                                                                  : test_idx_reg + 3'h1;
        end
    end

    // Reset value matches edge select reset level high: rest low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_out      <= 8'h00;
            output_strobe <= 1'b0;
        end else begin
            unique case (mode)
                acb_pkg::ACB_MODE_TEST: begin
                    // advanced only by the readout clock
                    if (rck_rise) begin
                        data_out      <= test_idx_reg[0] ? 8'hff : 8'h00;
                        output_strobe <= edge_sel;
                    end else if (rck_fall) begin
                        output_strobe <= ~edge_sel;
                    end
                end
                acb_pkg::ACB_MODE_BYPASS: begin
                    // live sample each cycle, strobe toggles; both hold their value in converter shutdown
                    // live output while idle in bypass unless the converter is shut down
                    data_out      <= conv_sd ? data_out : sample_data;
                    output_strobe <= conv_sd ? output_strobe : ~output_strobe;
                end
                acb_pkg::ACB_MODE_BUFFER: begin
                    // bytes move only on readout rises
                    if (rd_step) begin
                        data_out      <= mem_rdata;
                        output_strobe <= edge_sel;
                    end else if (rck_fall | wr_active) begin
                        output_strobe <= ~edge_sel;
                        if (!read_phase) begin
                            data_out <= {8{~edge_sel}};
                        end
                    end
                end
                acb_pkg::ACB_MODE_OFF: begin
                    data_out      <= {8{~edge_sel}};
                    output_strobe <= ~edge_sel;
                end
            endcase
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    logic                   aw_held_reg, w_held_reg;
    logic [`ACB_ADDR_W-1:0] aw_addr_reg;
    logic [31:0]            w_data_reg;
    logic [3:0]             w_strb_reg;
    logic                   wr_commit;
    logic [31:0]            status_word;

    assign wr_commit = aw_held_reg & w_held_reg & ~bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
            awready     <= 1'b1;
            wready      <= 1'b1;
            bvalid      <= 1'b0;
            bresp       <= acb_pkg::ACB_RESP_OKAY;
        end else begin
            if (awvalid & awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= awaddr;
                awready     <= 1'b0;
            end
            if (wvalid & wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
                wready     <= 1'b0;
            end
            if (wr_commit) begin
                bvalid <= 1'b1;
                bresp  <= (aw_addr_reg[`ACB_ADDR_W-1:2] == `ACB_ADDR_CTRL >> 2 ||
                           aw_addr_reg[`ACB_ADDR_W-1:2] == `ACB_ADDR_STATUS >> 2)
                          ? acb_pkg::ACB_RESP_OKAY : acb_pkg::ACB_RESP_SLVERR;
            end
            if (bvalid & bready) begin
                bvalid      <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                awready     <= 1'b1;
                wready      <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `ACB_CTRL_RESET;
        end else if (wr_commit && w_strb_reg[0] &&
                     aw_addr_reg[`ACB_ADDR_W-1:2] == `ACB_ADDR_CTRL >> 2) begin
            ctrl_reg <= w_data_reg[`ACB_CTRL_W-1:0];
        end
    end

    always_comb begin
        status_word                                           = '0;
        status_word[`ACB_STAT_EMPTY]                          = buffer_empty_flag;
        status_word[`ACB_STAT_FULL]                           = buffer_full_flag;
        status_word[`ACB_STAT_WRITING]                        = wr_active;
        status_word[`ACB_STAT_READ_OK]                        = read_ok_reg;
        status_word[`ACB_STAT_COUNT_LSB +: `ACB_CNT_W]        = count_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= acb_pkg::ACB_RESP_OKAY;
        end else if (arvalid & arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            if (araddr[`ACB_ADDR_W-1:2] == `ACB_ADDR_CTRL >> 2) begin
                rdata <= {{(32-`ACB_CTRL_W){1'b0}}, ctrl_reg};
                rresp <= acb_pkg::ACB_RESP_OKAY;
            end else if (araddr[`ACB_ADDR_W-1:2] == `ACB_ADDR_STATUS >> 2) begin
                rdata <= status_word;
                rresp <= acb_pkg::ACB_RESP_OKAY;
            end else begin
                rdata <= '0;
                rresp <= acb_pkg::ACB_RESP_SLVERR;
            end
        end else if (rvalid & rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ==========================================================
    // Assertions
    default clocking acb_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_read_order;
        rd_step |=> data_out == $past(mem_rdata);
    endproperty
    a_read_order: assert property (p_read_order) else $error("read byte mismatch");

    property p_read_after_fill;
        rd_step |-> read_ok_reg && !wr_active;
    endproperty
    a_read_after_fill: assert property (p_read_after_fill) else $error("early read");

    property p_full_rise;
        $rose(buffer_full_flag) |-> count_reg >= $past(depth);
    endproperty
    a_full_rise: assert property (p_full_rise) else $error("full flag early");

    property p_no_reread;
        (count_reg == '0 && !wr_start) |-> !rd_step ##1 count_reg == '0 || wr_active;
    endproperty
    a_no_reread: assert property (p_no_reread) else $error("drained data reread");

    property p_restart;
        wr_start |=> rptr_reg == '0 && count_reg == 11'h001 && !read_ok_reg;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear");

    property p_overwrite;
        (wr_active && !wr_start && at_depth && !auto_stop)
            |=> count_reg == $past(count_reg) && rptr_reg != $past(rptr_reg);
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("no overwrite");

    property p_auto_stop;
        (wr_active && !wr_start && at_depth && auto_stop) |-> !mem_we;
    endproperty
    a_auto_stop: assert property (p_auto_stop) else $error("auto-stop failed");

    property p_bypass_flags;
        // Flags lag the mode by one stage, reset values included
        (mode == acb_pkg::ACB_MODE_BYPASS) [*2] |=> !buffer_empty_flag && !buffer_full_flag;
    endproperty
    a_bypass_flags: assert property (p_bypass_flags) else $error("bypass flags set");

    property p_shutdown_write;
        conv_sd |-> !mem_we;
    endproperty
    a_shutdown_write: assert property (p_shutdown_write) else $error("write in shutdown");

    property p_empty_rise;
        $rose(buffer_empty_flag) |-> count_reg == '0;
    endproperty
    a_empty_rise: assert property (p_empty_rise) else $error("empty flag wrong");

    property p_rest_level;
        (mode == acb_pkg::ACB_MODE_BUFFER && rck_fall && !read_phase && !rd_step)
            |=> output_strobe == ~edge_sel && data_out == {8{~edge_sel}};
    endproperty
    a_rest_level: assert property (p_rest_level) else $error("bad rest level");

    c_capture:  cover property (wr_start ##[1:1000] buffer_full_flag);
    c_drain:    cover property (rd_step && count_reg == 11'h001);
    c_restart:  cover property (read_phase ##1 wr_start);
    c_pattern:  cover property (mode == acb_pkg::ACB_MODE_TEST && rck_rise);

endmodule : acb_ctrl
`default_nettype wire

//--- dv/acb_reader.sv
// Far-side reader model driving the readout gate and readout clock
`timescale 1ns/100ps
`default_nettype none
module acb_reader (
    output var logic read_gate,
    output var logic readout_clock
);
    initial {read_gate, readout_clock} = 2'h0;
    // clock runs only in frames, parked low
    task automatic read_n(input int n, input int half);
        // Gate moves off the sampling edge of the block's clock
        #3;
        read_gate = 1'b1;
        #104;
        repeat (n) begin
            readout_clock = 1'b1;
            #half;
            readout_clock = 1'b0;
            #half;
        end
        read_gate = 1'b0;
        #53;
    endtask : read_n
endmodule : acb_reader
`default_nettype wire

//--- dv/adc_capture_buffer_control_test.sv
// Self-checking bench of the capture buffer control
`timescale 1ns/100ps
`default_nettype none
module adc_capture_buffer_control_test;
    logic        aclk = 1'b0, aresetn = 1'b0, write_gate = 1'b0, hit, strobe_q;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, read_gate, readout_clock;
    logic        output_strobe, buffer_empty_flag, buffer_full_flag;
    logic [1:0]  bresp, rresp, rr;
    logic [3:0]  wstrb = 4'hf;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, sample_data = 8'h00, step = 8'h01;
    logic [7:0]  data_out, prev_s, s_end, q[$];
    logic [31:0] wdata = 32'h0, rdata, rd, rs = 32'h166dc;
    int          n_errors = 0, cmp_count = 0, cyc = 0, n, depth, k;
    always #10 aclk = ~aclk;
    acb_ctrl dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .sample_data, .write_gate, .read_gate, .readout_clock, .data_out,
        .output_strobe, .buffer_empty_flag, .buffer_full_flag);
    acb_reader rdr_u (.read_gate, .readout_clock);
    always @(posedge aclk) begin
        prev_s <= sample_data;
        strobe_q <= output_strobe;
        sample_data <= sample_data + step;
        cyc <= cyc + 1;
        if (output_strobe && !strobe_q) q.push_back(data_out);
        if (cyc == 60000) complete_run(1);
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        n_errors += (seen !== exp);
        if (seen !== exp) $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            {awvalid, wvalid} <= {awvalid & ~awready, wvalid & ~wready};
        end while (!bvalid);
        bready <= 1'b0;
        rr = bresp;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            arvalid <= arvalid & ~arready;
        end while (!rvalid);
        rready <= 1'b0;
        {rr, rd} = {rresp, rdata};
    endtask : axi_rd
    task automatic complete_run(input int extra);
        n_errors += extra;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_wr(8'h0c, 32'h7f);
        chk(rr, 2'h2); // unmapped write refused
        axi_rd(8'h00);
        chk(rd, 32'h8); // bypass at reset
        axi_rd(8'h0c);
        chk({rr, rd}, {2'h2, 32'h0}); // unmapped refused
        write_gate <= 1'b1;
        // Strobe toggles each cycle, so its delayed copy always differs
        repeat (20) @(posedge aclk) chk({data_out, buffer_empty_flag, buffer_full_flag,
            output_strobe ^ strobe_q}, {prev_s, 3'h1}); // live output
        write_gate <= 1'b0;
        for (int c = 1; c < 4; c++) begin
            depth = 128 << c;
            rs = xs(rs);
            k = 1 + rs[15:8];
            // Odd step keeps the ramp invertible, so any byte locates its sample
            step <= rs[7:0] | 8'h01;
            axi_wr(8'h00, 32'h8 | c | ((c & 1) << 2));
            write_gate <= 1'b1;
            for (n = 0; buffer_full_flag !== 1'b1; n++) @(posedge aclk);
            chk(n > depth && n < depth + 7, 1'b1); // full timing
            repeat (20) @(posedge aclk);
            write_gate <= 1'b0;
            s_end = sample_data;
            repeat (6) @(posedge aclk);
            chk({buffer_full_flag, buffer_empty_flag}, 2'h2); // flags held
            axi_rd(8'h04);
            chk(rd, (depth << 16) | 32'ha); // full, readable, count
            // Largest depth is read with the converter shut down
            if (c == 3) axi_wr(8'h00, 32'h4f); // readout in converter shutdown
            q.delete();
            rdr_u.read_n(k, 80); // read once full
            rdr_u.read_n(depth - k, 80); // resume after a pause
            rdr_u.read_n(3, 80);
            repeat (8) @(posedge aclk);
            chk(q.size(), depth); // byte count
            for (int i = 1; i < depth; i++) chk(q[i], 8'(q[i-1] + step)); // order
            hit = 1'b0;
            for (int j = -2; j < 8; j++) hit |= q[depth-1] === 8'(s_end + j * step);
            chk(hit, !(c & 1)); // newest byte
            chk({buffer_empty_flag, buffer_full_flag, output_strobe, data_out},
                11'h400); // rest levels
        end
        write_gate <= 1'b1;
        repeat (10) @(posedge aclk);
        chk({buffer_empty_flag, buffer_full_flag}, 2'h2); // gate ignored in shutdown
        write_gate <= 1'b0;
        axi_wr(8'h00, 32'h18);
        q.delete();
        rdr_u.read_n(10, 80);
        repeat (8) @(posedge aclk);
        chk(q.size(), 10); // pattern count
        for (int i = 0; i < 10; i++) chk(q[i], (i % 5) % 2 ? 8'hff : 8'h00); // codes
        axi_wr(8'h00, 32'h27);
        repeat (2) @(posedge aclk);
        // Full shutdown with edge select low: outputs rest high, flags low
        chk({buffer_empty_flag, buffer_full_flag, output_strobe, data_out}, 11'h1ff);
        complete_run(0);
    end
endmodule : adc_capture_buffer_control_test
`default_nettype wire
